// file: smc_ctrl.sv
`timescale 1ns/100ps
module smc_ctrl
  import smc_pkg::*;
#(
  parameter logic [31:0] DR7_RESET_VALUE = 32'h0000_0000
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              suspend_request_n,
  input  wire logic              mgmt_int_n,
  input  wire logic              addr20_mask_n,
  input  wire logic              nmi_req,
  input  wire smc_core_evt_s     evt,
  input  wire logic [31:0]       mem_addr,
  output logic                   suspend_ack_n,
  output logic                   core_stall,
  output logic                   mgmt_cycle_marker_n,
  output logic                   mgmt_active_n,
  output logic                   undef_opcode_fault,
  output logic                   mem_to_mgmt,
  output logic                   addr20_mask_eff_n,
  output logic                   nmi_take,
  output logic                   mgmt_entry,
  output logic                   dr7_reload,
  output logic      [31:0]       dr7_reload_value,
  output logic      [5:0]        save_mask,
  output logic      [31:0]       save_area_base,
  output logic      [31:0]       region_top,
  output logic      [31:0]       entry_ip_addr,
  output logic      [31:0]       cs_limit
);

  // Pin synchronisers, stage one read only by stage two
  logic [1:0] suspend_request_n_sync_r;  // Suspend request
  logic [1:0] mint_sync_r;  // Management interrupt
  logic [1:0] a20_sync_r;   // Address mask
  logic [1:0] nmi_sync_r;   // Non-maskable request
  // Configuration and state
  logic [7:0]  cfg_one_r;     // Access and nmi bits
  logic [7:0]  cfg_two_r;     // Suspend bits
  logic [7:0]  cfg_three_r;   // Protocol select
  logic [31:0] region_r;      // Base page and size code
  smc_suspend_request_n_e   suspend_request_n_r;        // Suspend state
  logic        mgmt_r;        // In management mode
  logic        nmi_prev_r;    // Edge detect of nmi
  // Decoded fields
  logic        suspend_request_n_en;       // Enable bit
  logic        halt_suspend_request_n;     // Halt suspend bit
  logic        compat;        // Alternate protocol
  logic        mgmt_acc;      // Management memory access
  logic        main_acc;      // Main memory access
  logic        nmi_en;        // Nmi allowed in management
  logic [31:0] base_addr;     // Region start
  logic [31:0] size_bytes;    // Region length
  logic [31:0] top_addr;      // One past region end
  logic        in_region;     // Address hits region
  logic        mgmt_req;      // Entry request this cycle
  logic        steer_nxt;     // Steering decision
  assign suspend_request_n_en    = cfg_two_r[CFG2_SUSPEND_REQUEST_N_EN_BIT];
  assign halt_suspend_request_n  = cfg_two_r[CFG2_HALT_SUSPEND_REQUEST_N_BIT];
  assign compat     = cfg_three_r[CFG3_COMPAT_BIT];
  assign mgmt_acc   = cfg_one_r[CFG1_MGMT_ACC_BIT];
  assign main_acc   = cfg_one_r[CFG1_MAIN_ACC_BIT];
  assign nmi_en     = cfg_one_r[CFG1_NMI_EN_BIT];
  assign base_addr  = {region_r[REGION_BASE_LSB +: REGION_BASE_W], 12'h000};
  assign size_bytes = 32'h0000_1000 << region_r[REGION_SIZE_LSB +: REGION_SIZE_W];
  assign top_addr   = base_addr + size_bytes;
  assign in_region  = (mem_addr >= base_addr) && (mem_addr < top_addr);
  // Pin synchroniser chains
  always_ff @(posedge clk) begin
    if (reset) begin
      suspend_request_n_sync_r <= 2'h3;
      mint_sync_r <= 2'h3;
      a20_sync_r  <= 2'h3;
      nmi_sync_r  <= 2'h0;
    end else begin
      suspend_request_n_sync_r <= {suspend_request_n_sync_r[0], suspend_request_n};
      mint_sync_r <= {mint_sync_r[0], mgmt_int_n};
      a20_sync_r  <= {a20_sync_r[0], addr20_mask_n};
      nmi_sync_r  <= {nmi_sync_r[0], nmi_req};
    end
  end
  // Register writes; power-up clears all enables
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_one_r   <= CFG_RESET;
      cfg_two_r   <= CFG_RESET;
      cfg_three_r <= CFG_RESET;
      region_r    <= REGION_RESET;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CFG_ONE) begin
        cfg_one_r <= reg_wdata[7:0];
      end else if (reg_addr == OFS_CFG_TWO) begin
        cfg_two_r <= reg_wdata[7:0];
      end else if (reg_addr == OFS_CFG_THREE) begin
        cfg_three_r <= reg_wdata[7:0];
      end else if (reg_addr == OFS_REGION) begin
        region_r <= reg_wdata;
        // Clamp size code to the largest region
        if (reg_wdata[REGION_SIZE_LSB +: REGION_SIZE_W] > REGION_SIZE_MAX) begin
          region_r[REGION_SIZE_LSB +: REGION_SIZE_W] <= REGION_SIZE_MAX;
        end
      end
    end
  end
  // Register reads, data one cycle later, unmapped reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (reg_addr == OFS_CFG_ONE) begin
        reg_rdata <= {24'h000000, cfg_one_r};
      end else if (reg_addr == OFS_CFG_TWO) begin
        reg_rdata <= {24'h000000, cfg_two_r};
      end else if (reg_addr == OFS_CFG_THREE) begin
        reg_rdata <= {24'h000000, cfg_three_r};
      end else if (reg_addr == OFS_REGION) begin
        reg_rdata <= region_r;
      end else if (reg_addr == OFS_STATUS) begin
        reg_rdata <= {28'h0000000, mgmt_r, compat, suspend_request_n_r};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
  // Suspend state machine and acknowledge
  always_ff @(posedge clk) begin
    if (reset) begin
      suspend_request_n_r        <= SUSPEND_REQUEST_N_RUN;
      suspend_ack_n <= 1'b1;
      core_stall    <= 1'b0;
    end else begin
      case (suspend_request_n_r)
        SUSPEND_REQUEST_N_RUN: begin
          if (suspend_request_n_en && !suspend_request_n_sync_r[1]) begin
            suspend_request_n_r        <= SUSPEND_REQUEST_N_PIN;
            suspend_ack_n <= 1'b0;
            core_stall    <= 1'b1;
          end else if (evt.halt_exec && halt_suspend_request_n) begin
            suspend_request_n_r        <= SUSPEND_REQUEST_N_HALT;
            suspend_ack_n <= 1'b0;
            core_stall    <= 1'b1;
          end
        end
        SUSPEND_REQUEST_N_PIN: begin
          // Clock may stop here; request negated only after restart
          if (suspend_request_n_sync_r[1]) begin
            suspend_request_n_r        <= SUSPEND_REQUEST_N_RUN;
            suspend_ack_n <= 1'b1;
            core_stall    <= 1'b0;
          end
        end
        SUSPEND_REQUEST_N_HALT: begin
          // An interrupt or reset wakes a halted core
          if (evt.wake_event) begin
            suspend_request_n_r        <= SUSPEND_REQUEST_N_RUN;
            suspend_ack_n <= 1'b1;
            core_stall    <= 1'b0;
          end
        end
        default: begin
          suspend_request_n_r        <= SUSPEND_REQUEST_N_RUN;
          suspend_ack_n <= 1'b1;
          core_stall    <= 1'b0;
        end
      endcase
    end
  end
  // Entry request: pin level, or soft opcode outside compat mode
  assign mgmt_req = !mgmt_r && (!mint_sync_r[1] || (evt.soft_int_exec && !compat));
  // Management mode flag and entry pulses
  always_ff @(posedge clk) begin
    if (reset) begin
      mgmt_r     <= 1'b0;
      mgmt_entry <= 1'b0;
      dr7_reload <= 1'b0;
    end else begin
      mgmt_entry <= mgmt_req;
      dr7_reload <= mgmt_req;
      if (mgmt_req) begin
        mgmt_r <= 1'b1;
      end else if (evt.resume_exec) begin
        mgmt_r <= 1'b0;
      end
    end
  end
  // Undefined opcode fault for soft entry in compat mode
  always_ff @(posedge clk) begin
    if (reset) begin
      undef_opcode_fault <= 1'b0;
    end else begin
      undef_opcode_fault <= evt.soft_int_exec && compat;
    end
  end
  // Entry layout for the core: save set, save area, entry point
  always_ff @(posedge clk) begin
    if (reset) begin
      save_mask        <= 6'h00;
      save_area_base   <= 32'h0000_0000;
      region_top       <= 32'h0000_0000;
      entry_ip_addr    <= 32'h0000_0000;
      cs_limit         <= 32'h0000_0000;
      dr7_reload_value <= 32'h0000_0000;
    end else begin
      save_mask        <= SAVE_MASK_ALL;
      region_top       <= top_addr;
      save_area_base   <= top_addr - SAVE_BYTES;
      entry_ip_addr    <= base_addr + ENTRY_IP_OFS;
      cs_limit         <= CS_LIMIT_64K;
      dr7_reload_value <= DR7_RESET_VALUE;
    end
  end
  // Memory steering to management or main memory
  always_comb begin
    steer_nxt = 1'b0;
    if (in_region) begin
      if (compat) begin
        steer_nxt = mgmt_r;
      end else if (mgmt_r) begin
        steer_nxt = !(main_acc && !evt.mem_code_seg);
      end else begin
        steer_nxt = mgmt_acc;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_to_mgmt <= 1'b0;
    end else begin
      mem_to_mgmt <= steer_nxt;
    end
  end
  // Marker pin: per-cycle pulse, or held level in compat mode
  always_ff @(posedge clk) begin
    if (reset) begin
      mgmt_cycle_marker_n <= 1'b1;
      mgmt_active_n       <= 1'b1;
    end else begin
      mgmt_active_n <= !(mgmt_r || mgmt_req);
      if (compat) begin
        mgmt_cycle_marker_n <= !((mgmt_r || mgmt_req) && !evt.resume_exec);
      end else begin
        mgmt_cycle_marker_n <= !(evt.mem_cycle_start && steer_nxt);
      end
    end
  end
  // Effective address mask, ignored in management mode
  always_ff @(posedge clk) begin
    if (reset) begin
      addr20_mask_eff_n <= 1'b1;
    end else begin
      addr20_mask_eff_n <= mgmt_r ? 1'b1 : a20_sync_r[1];
    end
  end
  // Nmi gating, blocked in management mode unless enabled
  always_ff @(posedge clk) begin
    if (reset) begin
      nmi_prev_r <= 1'b0;
      nmi_take   <= 1'b0;
    end else begin
      nmi_prev_r <= nmi_sync_r[1];
      nmi_take   <= nmi_sync_r[1] && !nmi_prev_r && (!mgmt_r || nmi_en);
    end
  end
  // Checks
  AST_SUSPEND_REQUEST_N_DISABLED: assert property (@(posedge clk) disable iff (reset)
    (suspend_request_n_r == SUSPEND_REQUEST_N_RUN && !suspend_request_n_en && !(evt.halt_exec && halt_suspend_request_n)) |=> suspend_request_n_r == SUSPEND_REQUEST_N_RUN)
    else $error("suspend entered while disabled");
  AST_PIN_ENTRY: assert property (@(posedge clk) disable iff (reset)
    (suspend_request_n_r == SUSPEND_REQUEST_N_RUN && suspend_request_n_en && !suspend_request_n_sync_r[1]) |=> suspend_request_n_r == SUSPEND_REQUEST_N_PIN)
    else $error("enabled request did not suspend");
  AST_PIN_HOLD: assert property (@(posedge clk) disable iff (reset)
    (suspend_request_n_r == SUSPEND_REQUEST_N_PIN && !suspend_request_n_sync_r[1]) |=> suspend_request_n_r == SUSPEND_REQUEST_N_PIN && !suspend_ack_n)
    else $error("left pin suspend while request low");
  AST_ACK_MATCH: assert property (@(posedge clk) disable iff (reset)
    suspend_ack_n == (suspend_request_n_r == SUSPEND_REQUEST_N_RUN))
    else $error("acknowledge disagrees with suspend state");
  AST_HALT_ENTRY: assert property (@(posedge clk) disable iff (reset)
    (suspend_request_n_r == SUSPEND_REQUEST_N_RUN && suspend_request_n_sync_r[1] && evt.halt_exec && halt_suspend_request_n) |=> !suspend_ack_n ##0 core_stall)
    else $error("halt did not suspend");
  AST_ACK_RELEASE: assert property (@(posedge clk) disable iff (reset)
    (suspend_request_n_r == SUSPEND_REQUEST_N_HALT && evt.wake_event) |=> suspend_ack_n && !core_stall)
    else $error("acknowledge not released on wake");
  AST_COMPAT_HOLD: assert property (@(posedge clk) disable iff (reset)
    (compat && mgmt_r && !evt.resume_exec) ##1 compat |-> !mgmt_cycle_marker_n)
    else $error("compat marker not held");
  AST_FAULT: assert property (@(posedge clk) disable iff (reset)
    (evt.soft_int_exec && compat) |=> undef_opcode_fault ##0 (mgmt_entry == (!$past(mgmt_r) && !$past(mint_sync_r[1]))))
    else $error("soft opcode not faulted in compat mode");
  AST_SAVE_AREA: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> (region_top - save_area_base == 32'd48))
    else $error("save area not 48 bytes");
  AST_A20_IGNORED: assert property (@(posedge clk) disable iff (reset)
    $past(mgmt_r) |-> addr20_mask_eff_n)
    else $error("address mask applied in management mode");
  AST_NMI_BLOCK: assert property (@(posedge clk) disable iff (reset)
    $past(mgmt_r) && !$past(nmi_en) |-> !nmi_take)
    else $error("nmi taken while blocked");
  AST_DR7_ENTRY: assert property (@(posedge clk) disable iff (reset)
    mgmt_req |=> dr7_reload && mgmt_entry ##1 !dr7_reload)
    else $error("debug reload not pulsed on entry");

endmodule

// file: smc_pkg.sv
package smc_pkg;
  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] OFS_CFG_ONE   = 8'h00;
  localparam logic [7:0] OFS_CFG_TWO   = 8'h04;
  localparam logic [7:0] OFS_CFG_THREE = 8'h08;
  localparam logic [7:0] OFS_REGION    = 8'h0c;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  // Field positions
  localparam int unsigned CFG1_NMI_EN_BIT   = 0;
  localparam int unsigned CFG1_MGMT_ACC_BIT = 2;
  localparam int unsigned CFG1_MAIN_ACC_BIT = 3;
  localparam int unsigned CFG2_SUSPEND_REQUEST_N_EN_BIT  = 7;
  localparam int unsigned CFG2_HALT_SUSPEND_REQUEST_N_BIT = 3;
  localparam int unsigned CFG3_COMPAT_BIT   = 3;
  localparam int unsigned REGION_BASE_LSB   = 0;
  localparam int unsigned REGION_BASE_W     = 20;
  localparam int unsigned REGION_SIZE_LSB   = 24;
  localparam int unsigned REGION_SIZE_W     = 4;
  localparam logic [3:0]  REGION_SIZE_MAX   = 4'hd;
  localparam int unsigned PAGE_SHIFT        = 12;
  // Reset values
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam logic [31:0] REGION_RESET = 32'h0000_0000;
  // Management entry layout
  localparam int unsigned SAVE_DWORDS   = 12;
  localparam logic [31:0] SAVE_BYTES    = 32'(SAVE_DWORDS * 4);
  localparam logic [31:0] ENTRY_IP_OFS  = 32'h0000_0000;
  localparam logic [31:0] CS_LIMIT_64K  = 32'h0000_ffff;
  // Restore offsets below region top
  localparam logic [7:0] RST_OFS_CR0     = 8'h0c;
  localparam logic [7:0] RST_OFS_DR7     = 8'h04;
  localparam logic [7:0] RST_OFS_FLAGS   = 8'h08;
  localparam logic [7:0] RST_OFS_IP      = 8'h14;
  localparam logic [7:0] RST_OFS_CS_DESC = 8'h20;
  localparam logic [7:0] RST_OFS_CS_SEL  = 8'h18;
  // Saved items: dr7, flags, cr0, cur ip, next ip, cs
  localparam logic [5:0] SAVE_MASK_ALL = 6'h3f;
  // Core event strobes, one cycle each
  typedef struct packed {
    logic halt_exec;
    logic soft_int_exec;
    logic resume_exec;
    logic wake_event;
    logic mem_cycle_start;
    logic mem_code_seg;
  } smc_core_evt_s;
  // Suspend states
  typedef enum logic [1:0] {SUSPEND_REQUEST_N_RUN, SUSPEND_REQUEST_N_PIN, SUSPEND_REQUEST_N_HALT} smc_suspend_request_n_e;
endpackage

// file: smc_partner.sv
`timescale 1ns/100ps
// Chipset side: drives the suspend and management pins
module smc_partner (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic sleep_want,
  input  wire logic int_want,
  input  wire logic suspend_ack_n,
  input  wire logic mgmt_active_n,
  output logic      suspend_request_n,
  output logic      mgmt_int_n
);
  // Ack low seen: clock could be stopped from here on
  logic ack_seen_r;
  // Track ack so a clock stop never precedes it
  always_ff @(posedge clk) begin
    ack_seen_r <= !reset && !suspend_ack_n;
  end
  // Request pin; released only once acknowledge was seen, clock kept running
  always_ff @(posedge clk) begin
    if (reset) begin
      suspend_request_n <= 1'b1;
    end else if (sleep_want) begin
      suspend_request_n <= 1'b0;
    end else if (ack_seen_r) begin
      suspend_request_n <= 1'b1;
    end
  end
  // Alternate protocol: hold interrupt until active indicator low
  always_ff @(posedge clk) begin
    if (reset || !mgmt_active_n) begin
      mgmt_int_n <= 1'b1;
    end else if (int_want) begin
      mgmt_int_n <= 1'b0;
    end
  end
endmodule

// file: test_suspend_and_sysmgmt_mode_control.sv
`timescale 1ns/100ps
module test_suspend_and_sysmgmt_mode_control;
  import smc_pkg::*;
  logic          clk = 1'b0;
  logic          reset = 1'b1;
  logic [7:0]    reg_addr = 8'h00;
  logic [31:0]   reg_wdata = 32'h0;
  logic          reg_wr = 1'b0, reg_rd = 1'b0;
  logic          sleep_want = 1'b0, int_want = 1'b0;
  logic          addr20_mask_n = 1'b1, nmi_req = 1'b0;
  smc_core_evt_s evt = '0;
  logic [31:0]   mem_addr = 32'h0;
  logic [31:0]   reg_rdata, dr7_reload_value, save_area_base, region_top, entry_ip_addr, cs_limit;
  logic          suspend_request_n, mgmt_int_n, suspend_ack_n, core_stall, mgmt_cycle_marker_n;
  logic          mgmt_active_n, undef_opcode_fault, mem_to_mgmt, addr20_mask_eff_n;
  logic          nmi_take, mgmt_entry, dr7_reload;
  logic [5:0]    save_mask;
  int            err_count = 0, checked = 0, i;
  logic [15:0]   seed = 16'h000a;

  smc_ctrl u_smc_ctrl (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .suspend_request_n, .mgmt_int_n, .addr20_mask_n, .nmi_req, .evt, .mem_addr, .suspend_ack_n,
    .core_stall, .mgmt_cycle_marker_n, .mgmt_active_n, .undef_opcode_fault, .mem_to_mgmt,
    .addr20_mask_eff_n, .nmi_take, .mgmt_entry, .dr7_reload, .dr7_reload_value, .save_mask,
    .save_area_base, .region_top, .entry_ip_addr, .cs_limit);
  smc_partner u_smc_partner (.clk, .reset, .sleep_want, .int_want, .suspend_ack_n,
    .mgmt_active_n, .suspend_request_n, .mgmt_int_n);

  // Free running clock
  always #4 clk = ~clk;

  // Pseudo random source
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected steering decision
  function automatic logic steer(input logic inr, cmp, mg, macc, mainacc, code);
    if (!inr) return 1'b0;
    if (cmp) return mg;
    if (mg) return !(mainacc && !code);
    return macc;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(reg_rdata, exp);
  endtask
  // One cycle core event, then one edge so its result is visible
  task automatic pulse(input smc_core_evt_s e);
    evt <= e;
    @(posedge clk);
    evt <= '0;
    @(posedge clk);
  endtask
  // Bounded wait for a level
  task automatic waitfor(ref logic s, input logic v);
    for (int k = 0; k < 8 && s !== v; k++) @(posedge clk);
    chk(s, v);
  endtask
  // Random accesses in and around an 8K region at a0000
  task automatic steer_run(input logic cmp, mg, macc, mainacc);
    for (int k = 0; k < 10; k++) begin
      seed = lfsr(seed);
      mem_addr <= (seed[15] ? 32'h000b_0000 : 32'h000a_0000) + 32'(seed[12:0]);
      evt <= smc_core_evt_s'({5'h00, seed[14]});
      @(posedge clk);
      @(posedge clk);
      chk(mem_to_mgmt, steer(!seed[15], cmp, mg, macc, mainacc, seed[14]));
    end
    evt <= '0;
    @(posedge clk);
  endtask
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Run takes under two hundred cycles; cut off well beyond that
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(OFS_CFG_TWO, 32'h0);
    rd(8'h14, 32'h0);
    // Request while disabled is ignored
    sleep_want <= 1'b1;
    repeat (8) @(posedge clk);
    chk(suspend_ack_n, 1'b1);
    wr(OFS_CFG_TWO, 32'h80);
    waitfor(suspend_ack_n, 1'b0);
    chk(core_stall, 1'b1);
    for (i = 0; i < 10; i++) begin
      @(posedge clk);
      chk(suspend_ack_n, 1'b0);
    end
    rd(OFS_STATUS, 32'h1);
    sleep_want <= 1'b0;
    waitfor(suspend_ack_n, 1'b1);
    chk(core_stall, 1'b0);
    fin("pin suspend");
    // Halt with halt bit clear, then set with enable clear
    pulse(6'h20);
    chk(suspend_ack_n, 1'b1);
    pulse(6'h04);
    wr(OFS_CFG_TWO, 32'h08);
    pulse(6'h20);
    chk(suspend_ack_n, 1'b0);
    chk(core_stall, 1'b1);
    pulse(6'h04);
    chk(suspend_ack_n, 1'b1);
    fin("halt suspend");
    // Management entry by opcode, normal protocol
    wr(OFS_REGION, 32'h0100_00a0);
    wr(OFS_CFG_ONE, 32'h0c);
    addr20_mask_n <= 1'b0;
    pulse(6'h10);
    chk(mgmt_entry, 1'b1);
    chk(dr7_reload, 1'b1);
    chk(dr7_reload_value, 32'h0);
    chk(save_mask, 6'h3f);
    chk(save_area_base, 32'h000a_1fd0);
    chk(region_top, 32'h000a_2000);
    chk(entry_ip_addr, 32'h000a_0000);
    chk(cs_limit, 32'h0000_ffff);
    chk(mgmt_active_n, 1'b0);
    nmi_req <= 1'b1;
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      chk(nmi_take, 1'b0);
    end
    chk(addr20_mask_eff_n, 1'b1);
    nmi_req <= 1'b0;
    wr(OFS_CFG_ONE, 32'h0d);
    nmi_req <= 1'b1;
    waitfor(nmi_take, 1'b1);
    nmi_req <= 1'b0;
    // Normal protocol: marker pulses once per steered code access
    mem_addr <= 32'h000a_0100;
    pulse(6'h03);
    chk(mgmt_cycle_marker_n, 1'b0);
    @(posedge clk);
    chk(mgmt_cycle_marker_n, 1'b1);
    steer_run(1'b0, 1'b1, 1'b1, 1'b1);
    // Handler has already copied the restart pointer in software
    pulse(6'h08);
    // Active indicator follows the mode flag one cycle later
    @(posedge clk);
    chk(mgmt_active_n, 1'b1);
    repeat (3) @(posedge clk);
    chk(addr20_mask_eff_n, 1'b0);
    addr20_mask_n <= 1'b1;
    steer_run(1'b0, 1'b0, 1'b1, 1'b1);
    fin("management entry");
    // Compatible protocol
    wr(OFS_CFG_THREE, 32'h08);
    rd(OFS_STATUS, 32'h4);
    steer_run(1'b1, 1'b0, 1'b1, 1'b1);
    pulse(6'h10);
    chk(undef_opcode_fault, 1'b1);
    chk(mgmt_active_n, 1'b1);
    int_want <= 1'b1;
    @(posedge clk);
    int_want <= 1'b0;
    waitfor(mgmt_active_n, 1'b0);
    for (i = 0; i < 6; i++) begin
      pulse(6'h02);
      chk(mgmt_cycle_marker_n, 1'b0);
    end
    steer_run(1'b1, 1'b1, 1'b1, 1'b1);
    pulse(6'h08);
    chk(mgmt_cycle_marker_n, 1'b1);
    @(posedge clk);
    chk(mgmt_cycle_marker_n, 1'b1);
    chk(mgmt_active_n, 1'b1);
    fin("compatible protocol");
    tally_and_finish();
  end
endmodule
